// File: hdl/gpio_port.sv
/*
 four-bit gpio port with apb register access: data latch, direction,
 pullup, slew and drive controls per pin.
 assumes an apb master on pclk and pad cells that resolve pin_out/pin_oe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.svh"
module gpio_port #(
    parameter int PINS = `GP_PINS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_pullup_on,
    output logic [PINS-1:0] pin_slew_on,
    output logic [PINS-1:0] pin_drive_high
);
    // software registers, reserved bits not stored
    logic [PINS-1:0] port_data_latch_r, port_data_latch_nxt;
    logic [PINS-1:0] port_direction_r, port_direction_nxt;
    logic [PINS-1:0] port_pullup_enable_r, port_pullup_enable_nxt;
    logic [PINS-1:0] port_slew_enable_r, port_slew_enable_nxt;
    logic [PINS-1:0] port_drive_strength_r, port_drive_strength_nxt;
    // bus answer registers
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    // pad control registers
    logic [PINS-1:0] pin_out_r, pin_out_nxt;
    logic [PINS-1:0] pin_oe_r, pin_oe_nxt;
    logic [PINS-1:0] pullup_r, pullup_nxt;
    logic [PINS-1:0] slew_r, slew_nxt;
    logic [PINS-1:0] drive_r, drive_nxt;
    // synchronised pin levels
    logic [PINS-1:0] pin_data_bits;
    gpio_port_pkg::reg_sel_t sel;
    logic access;

    // address decode, shared by read and write paths
    function automatic gpio_port_pkg::reg_sel_t decode(input logic [11:0] a);
        case (a)
            `GP_OFS_DATA: decode = gpio_port_pkg::SEL_DATA;
            `GP_OFS_DIR: decode = gpio_port_pkg::SEL_DIR;
            `GP_OFS_PULLUP: decode = gpio_port_pkg::SEL_PULLUP;
            `GP_OFS_SLEW: decode = gpio_port_pkg::SEL_SLEW;
            `GP_OFS_DRIVE: decode = gpio_port_pkg::SEL_DRIVE;
            default: decode = gpio_port_pkg::SEL_NONE;
        endcase
    endfunction

    // pins cross two flops before any logic sees them
    pin_sync #(.WIDTH(PINS)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_data_bits)
    );

    assign sel = decode(paddr);
    // access phase completes in the first cycle: pready registered in setup
    assign access = psel && penable && pready_r;

    // register writes
    always_comb begin
        port_data_latch_nxt = port_data_latch_r;
        port_direction_nxt = port_direction_r;
        port_pullup_enable_nxt = port_pullup_enable_r;
        port_slew_enable_nxt = port_slew_enable_r;
        port_drive_strength_nxt = port_drive_strength_r;
        if (access && pwrite) begin
            case (sel)
                gpio_port_pkg::SEL_DATA: begin
                    port_data_latch_nxt = pwdata[PINS-1:0];
                end
                gpio_port_pkg::SEL_DIR: begin
                    port_direction_nxt = pwdata[PINS-1:0];
                end
                gpio_port_pkg::SEL_PULLUP: begin
                    port_pullup_enable_nxt = pwdata[PINS-1:0];
                end
                gpio_port_pkg::SEL_SLEW: begin
                    port_slew_enable_nxt = pwdata[PINS-1:0];
                end
                gpio_port_pkg::SEL_DRIVE: begin
                    port_drive_strength_nxt = pwdata[PINS-1:0];
                end
                // unmapped write: dropped, flagged by pslverr
                default: begin
                end
            endcase
        end
    end

    // bus answer: pready raised in setup so access lasts one cycle
    always_comb begin
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && (decode(paddr) == gpio_port_pkg::SEL_NONE);
        prdata_nxt = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (sel)
                gpio_port_pkg::SEL_DATA: begin
                    prdata_nxt[PINS-1:0] = (port_direction_r & port_data_latch_r)
                        | (~port_direction_r & pin_data_bits);
                end
                gpio_port_pkg::SEL_DIR: begin
                    prdata_nxt[PINS-1:0] = port_direction_r;
                end
                gpio_port_pkg::SEL_PULLUP: begin
                    prdata_nxt[PINS-1:0] = port_pullup_enable_r;
                end
                gpio_port_pkg::SEL_SLEW: begin
                    prdata_nxt[PINS-1:0] = port_slew_enable_r;
                end
                gpio_port_pkg::SEL_DRIVE: begin
                    prdata_nxt[PINS-1:0] = port_drive_strength_r;
                end
                default: begin
                    prdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // pad controls from the next register values; updated on the same edge as a write
    always_comb begin
        pin_out_nxt = port_data_latch_nxt & port_direction_nxt;
        pin_oe_nxt = port_direction_nxt;
        pullup_nxt = port_pullup_enable_nxt & ~port_direction_nxt;
        slew_nxt = port_slew_enable_nxt & port_direction_nxt;
        drive_nxt = port_drive_strength_nxt;
    end

    // all state; reset to zero, pins undriven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_latch_r <= `GP_RESET_VAL;
            port_direction_r <= `GP_RESET_VAL;
            port_pullup_enable_r <= `GP_RESET_VAL;
            port_slew_enable_r <= `GP_RESET_VAL;
            port_drive_strength_r <= `GP_RESET_VAL;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            pin_out_r <= '0;
            pin_oe_r <= '0;
            pullup_r <= '0;
            slew_r <= '0;
            drive_r <= '0;
        end else begin
            port_data_latch_r <= port_data_latch_nxt;
            port_direction_r <= port_direction_nxt;
            port_pullup_enable_r <= port_pullup_enable_nxt;
            port_slew_enable_r <= port_slew_enable_nxt;
            port_drive_strength_r <= port_drive_strength_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            pullup_r <= pullup_nxt;
            slew_r <= slew_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pin_pullup_on = pullup_r;
    assign pin_slew_on = slew_r;
    assign pin_drive_high = drive_r;

    // checks

    property p_oe_follows_dir;
        @(posedge pclk) disable iff (!presetn)
        pin_oe == port_direction_r;
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("oe differs from direction");

    property p_out_from_latch;
        @(posedge pclk) disable iff (!presetn)
        pin_out == (port_data_latch_r & port_direction_r);
    endproperty
    a_out_from_latch: assert property (p_out_from_latch) else $error("pin drive not latch");

    property p_pullup_off_out;
        @(posedge pclk) disable iff (!presetn)
        (pin_pullup_on & pin_oe) == '0;
    endproperty
    a_pullup_off_out: assert property (p_pullup_off_out) else $error("pullup on output pin");

    property p_pullup_in;
        @(posedge pclk) disable iff (!presetn)
        pin_pullup_on == (port_pullup_enable_r & ~port_direction_r);
    endproperty
    a_pullup_in: assert property (p_pullup_in) else $error("pullup wrong");

    property p_slew_in_none;
        @(posedge pclk) disable iff (!presetn)
        (pin_slew_on & ~pin_oe) == '0;
    endproperty
    a_slew_in_none: assert property (p_slew_in_none) else $error("slew on input pin");

    property p_slew_out;
        @(posedge pclk) disable iff (!presetn)
        pin_slew_on == (port_slew_enable_r & port_direction_r);
    endproperty
    a_slew_out: assert property (p_slew_out) else $error("slew wrong");

    property p_drive;
        @(posedge pclk) disable iff (!presetn)
        pin_drive_high == port_drive_strength_r;
    endproperty
    a_drive: assert property (p_drive) else $error("drive wrong");

    property p_data_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && sel == gpio_port_pkg::SEL_DATA)
            |=> port_data_latch_r == $past(pwdata[PINS-1:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("latch not updated");

    property p_read_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:PINS] == '0;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("reserved bits nonzero");

    property p_one_cycle_access;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_one_cycle_access: assert property (p_one_cycle_access) else $error("pready timing");

    // read mux: input bits show the synchronised pin level from setup
    property p_read_input;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel == gpio_port_pkg::SEL_DATA)
            |=> (prdata[PINS-1:0] & ~$past(port_direction_r))
            == ($past(pin_data_bits) & ~$past(port_direction_r));
    endproperty
    a_read_input: assert property (p_read_input) else $error("input bit not pin level");

    property p_read_output;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel == gpio_port_pkg::SEL_DATA)
            |=> (prdata[PINS-1:0] & $past(port_direction_r))
            == ($past(port_data_latch_r) & $past(port_direction_r));
    endproperty
    a_read_output: assert property (p_read_output) else $error("output bit not latch");

    property p_dir_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && sel == gpio_port_pkg::SEL_DIR)
            |=> port_direction_r == $past(pwdata[PINS-1:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not written");

    property p_pullup_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && sel == gpio_port_pkg::SEL_PULLUP)
            |=> pin_pullup_on == ($past(pwdata[PINS-1:0]) & ~port_direction_r);
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pullup pad wrong");

    property p_drive_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && sel == gpio_port_pkg::SEL_DRIVE)
            |=> pin_drive_high == $past(pwdata[PINS-1:0]);
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("drive pad wrong");

    // reset checks carry no disable so they see the reset cycles themselves
    property p_rst_latch;
        @(posedge pclk)
        !$past(presetn) |-> (port_data_latch_r == '0) && (pin_out == '0);
    endproperty
    a_rst_latch: assert property (p_rst_latch) else $error("latch not cleared");

    property p_rst_pads;
        @(posedge pclk)
        !$past(presetn) |-> (pin_oe == '0) && (pin_pullup_on == '0);
    endproperty
    a_rst_pads: assert property (p_rst_pads) else $error("pads driven after reset");
endmodule
`default_nettype wire

// File: pkg/gpio_port_consts.svh
/*
 constants for the four-bit gpio port: register offsets, field widths,
 and the reset value of the port registers.
 assumes it is included by bare name from package and design files.
*/
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH
`define GP_PINS 4
`define GP_OFS_DATA 12'h000
`define GP_OFS_DIR 12'h004
`define GP_OFS_PULLUP 12'h008
`define GP_OFS_SLEW 12'h00c
`define GP_OFS_DRIVE 12'h010
`define GP_RESET_VAL 4'h0
`endif

// File: pkg/gpio_port_pkg.sv
/*
 types for the four-bit gpio port.
 assumes the constants header sits beside it.
*/
`include "gpio_port_consts.svh"
package gpio_port_pkg;
    // register select decoded from the apb address
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_DATA = 3'h1,
        SEL_DIR = 3'h2,
        SEL_PULLUP = 3'h3,
        SEL_SLEW = 3'h4,
        SEL_DRIVE = 3'h5
    } reg_sel_t;
endpackage

// File: hdl/pin_sync.sv
/*
 two flip-flop synchroniser for the port pin inputs.
 assumes pins are asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r; // first stage, read only by second
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// File: tb/pin_board.sv
/*
 board model for the four port pins: external drivers, pullups, floating nets.
 assumes the port's pad outputs and pclk come from the testbench.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input wire logic pclk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pin_pullup_on,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] pin_level
);
    // floating nets flip every cycle so no read can lean on a stale level
    logic [3:0] float_r = 4'h0;
    always @(posedge pclk) begin
        float_r <= ~float_r;
    end
    // device driver wins, then board driver, then pullup, else floating
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pin_pullup_on[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/four_bit_gpio_port_test.sv
/*
 self-checking bench for the four-bit gpio port over apb.
 assumes the port, the pin board model and the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.svh"
module four_bit_gpio_port_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] lvl, p_out, p_oe, p_pu, p_sl, p_ds;
    logic [3:0] ext_en = 4'hf; // board drives every undriven pin
    logic [3:0] ext_val = 4'h0;
    logic [31:0] rd; // last read data
    logic err; // last slave error
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    // one row: direction, latch, pullup, slew, drive, board level, data read
    typedef struct packed {logic [3:0] dir, dat, pu, sl, ds, ext, exp_rd;} row_t;
    row_t rows [4] = '{'{4'h0, 4'hf, 4'h0, 4'hf, 4'h5, 4'ha, 4'ha},
        '{4'hf, 4'h6, 4'hf, 4'h3, 4'ha, 4'h0, 4'h6},
        '{4'h5, 4'hf, 4'ha, 4'hf, 4'hf, 4'h3, 4'h7},
        '{4'ha, 4'h5, 4'h5, 4'h0, 4'h0, 4'hc, 4'h4}};

    always #50 pclk = ~pclk; // 10 MHz

    gpio_port #(.PINS(4)) gpio_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(lvl),
        .pin_out(p_out), .pin_oe(p_oe), .pin_pullup_on(p_pu), .pin_slew_on(p_sl),
        .pin_drive_high(p_ds));

    pin_board pin_board_inst (.pclk(pclk), .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup_on(p_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_level(lvl));

    function automatic logic [31:0] z(input logic [3:0] v);
        return {28'h0, v};
    endfunction

    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready seen high at an edge
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no local limit: only the hang guard ends a stuck transfer
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk(n, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // after reset: undriven pads, all registers clear, latch holds zero
    task chk_reset();
        chk({p_oe, p_out, p_pu, p_sl, p_ds}, 32'h0);
        for (int a = 0; a < 5; a++) begin
            xfer(12'(4 * a), 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        xfer(`GP_OFS_DIR, 1'b1, 32'hf);
        xfer(`GP_OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask

    task conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 190 cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_reset();
        // table of pin configurations
        foreach (rows[i]) begin
            ext_en <= ~rows[i].dir;
            ext_val <= rows[i].ext;
            xfer(`GP_OFS_DIR, 1'b1, z(rows[i].dir));
            xfer(`GP_OFS_DATA, 1'b1, z(rows[i].dat));
            xfer(`GP_OFS_PULLUP, 1'b1, z(rows[i].pu));
            xfer(`GP_OFS_SLEW, 1'b1, z(rows[i].sl));
            xfer(`GP_OFS_DRIVE, 1'b1, z(rows[i].ds));
            repeat (4) @(posedge pclk);
            chk(z(p_oe), z(rows[i].dir));
            chk(z(p_out), z(rows[i].dat & rows[i].dir));
            chk(z(p_pu), z(rows[i].pu & ~rows[i].dir));
            chk(z(p_sl), z(rows[i].sl & rows[i].dir));
            chk(z(p_ds), z(rows[i].ds));
            xfer(`GP_OFS_DATA, 1'b0, 32'h0);
            chk(rd, z(rows[i].exp_rd));
        end
        // reserved upper bits ignored on write
        xfer(`GP_OFS_DIR, 1'b1, 32'hffff_fff5);
        xfer(`GP_OFS_DIR, 1'b0, 32'h0);
        chk(rd, 32'h5);
        // latch written while every pin is an input
        ext_en <= 4'hf;
        ext_val <= 4'h6;
        xfer(`GP_OFS_DIR, 1'b1, 32'h0);
        xfer(`GP_OFS_DATA, 1'b1, 32'h9);
        repeat (4) @(posedge pclk);
        xfer(`GP_OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h6);
        xfer(`GP_OFS_DIR, 1'b1, 32'hf);
        xfer(`GP_OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h9);
        // unmapped address refused, registers untouched
        xfer(12'h014, 1'b1, 32'h0);
        chk(z(err), 32'h1);
        xfer(12'h014, 1'b0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        xfer(`GP_OFS_DIR, 1'b0, 32'h0);
        chk(rd, 32'hf);
        // pullup holds an undriven input high
        xfer(`GP_OFS_DIR, 1'b1, 32'h0);
        xfer(`GP_OFS_PULLUP, 1'b1, 32'hf);
        ext_en <= 4'h0;
        repeat (4) @(posedge pclk);
        xfer(`GP_OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'hf);
        // second reset in mid-run
        xfer(`GP_OFS_DIR, 1'b1, 32'hf);
        ext_en <= 4'hf;
        ext_val <= 4'h0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(z(p_oe), 32'h0);
        presetn <= 1'b1;
        chk_reset();
        conclude();
    end
endmodule
`default_nettype wire
